/* File: sel_bus_eng.sv */
// Bit engine of the two-wire bus: start, stop, byte write, byte read.
// Assumes the memory never stretches the clock; the clock line is not read back.
module sel_bus_eng #(
   parameter int QTR_CYC = sel_pkg::SCL_QTR_CYC
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Command side
   input  wire logic             go,
   input  sel_pkg::sel_cmd_t     cmd,
   input  wire logic [7:0]       wdata,
   input  wire logic             send_ack,
   output logic                  busy,
   output logic                  done,
   output logic [7:0]            rdata,
   output logic                  nack,
   // Line levels, high means released
   output logic                  scl_rel,
   output logic                  sda_rel,
   input  wire logic             sda_in
);
   localparam int TW = $clog2(QTR_CYC + 1);

   logic              busy_q, done_q, ack_send_q, nack_q, scl_q, sda_q;
   sel_pkg::sel_cmd_t cmd_q;
   logic [TW-1:0]     tmr_q;
   logic [1:0]        ph_q;
   logic [3:0]        bit_q;
   logic [7:0]        sh_q;
   logic              scl_n, sda_n, wbit;

   // Phase timing and end of command
   wire tick     = busy_q && (tmr_q == TW'(QTR_CYC - 1));
   wire is_edge  = (cmd_q == sel_pkg::CMD_START) || (cmd_q == sel_pkg::CMD_STOP);
   wire last_bit = is_edge ? (bit_q == 4'h0) : (bit_q == 4'h8);
   wire fin      = tick && (ph_q == 2'h3) && last_bit;

   // Data bit on the line; ninth bit is the acknowledge slot
   assign wbit = (cmd_q == sel_pkg::CMD_WRITE) ? ((bit_q == 4'h8) ? 1'b1 : sh_q[7])
                                              : ((bit_q == 4'h8) ? ~ack_send_q : 1'b1);

   // Line levels per quarter; data only moves while the clock is low, except in start and stop
   always_comb begin
      unique case (cmd_q)
         sel_pkg::CMD_START: begin
            scl_n = (ph_q == 2'h1) || (ph_q == 2'h2);
            sda_n = (ph_q < 2'h2);
         end
         sel_pkg::CMD_STOP: begin
            scl_n = (ph_q != 2'h0);
            sda_n = (ph_q >= 2'h2);
         end
         default: begin
            scl_n = (ph_q == 2'h1) || (ph_q == 2'h2);
            sda_n = (ph_q == 2'h0) ? wbit : sda_q;
         end
      endcase
   end

   // Sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q     <= 1'b0;
         done_q     <= 1'b0;
         cmd_q      <= sel_pkg::CMD_START;
         tmr_q      <= '0;
         ph_q       <= 2'h0;
         bit_q      <= 4'h0;
         sh_q       <= 8'h00;
         ack_send_q <= 1'b0;
         nack_q     <= 1'b0;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
      end else begin
         done_q <= fin;
         if (go && !busy_q) begin
            busy_q     <= 1'b1;
            cmd_q      <= cmd;
            sh_q       <= wdata;
            ack_send_q <= send_ack;
            tmr_q      <= '0;
            ph_q       <= 2'h0;
            bit_q      <= 4'h0;
         end else if (busy_q) begin
            tmr_q <= tick ? '0 : tmr_q + TW'(1);
            if (tmr_q == '0) begin
               scl_q <= scl_n;
               sda_q <= sda_n;
            end
            if (tick && ph_q == 2'h2 && !is_edge) begin
               if (bit_q == 4'h8)
                  nack_q <= (cmd_q == sel_pkg::CMD_WRITE) && sda_in;
               else
                  sh_q <= {sh_q[6:0], sda_in};
            end
            if (tick) begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h3)
                  bit_q <= bit_q + 4'h1;
            end
            if (fin)
               busy_q <= 1'b0;
         end
      end
   end

   assign busy    = busy_q;
   assign done    = done_q;
   assign rdata   = sh_q;
   assign nack    = nack_q;
   assign scl_rel = scl_q;
   assign sda_rel = sda_q;

   // Data line moves under a high clock only for start and stop
   sda_stable_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      (scl_q && $past(scl_q) && sda_q != $past(sda_q)) |-> is_edge)
      else $error("data line moved while clock high");

   // A start or stop keeps the engine busy for at least four cycles
   cmd_length_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      $rose(busy_q) && is_edge |-> busy_q [*4])
      else $error("start or stop ended early");

endmodule : sel_bus_eng

/* File: sel_eeprom_model.sv */
// Behavioural two-wire memory holding the 15-byte configuration image.
// Assumes resolved wire levels with pull-ups; it only ever pulls data low.
module sel_eeprom_model (
   // Resolved bus wires
   input  wire logic             scl,
   input  wire logic             sda,
   // Image and fault control
   input  wire logic [14:0][7:0] image,
   input  wire logic             refuse,
   // Data pull-down and count of bytes sent
   output logic                  pull_low,
   output logic [7:0]            n_sent
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       scl_p, sda_p, active, first, rd_mode, go_rd, ok, quiet;
   logic [3:0] bitc, ptr;
   logic [7:0] sr, cur;

   // Idle and released at time zero
   initial begin
      {pull_low, active, go_rd, ok} = 4'h0;
      {scl_p, sda_p} = 2'h3;
      {n_sent, ptr} = 12'h000;
   end

   // Start and stop count only while the clock stays high; X levels are ignored
   always @(scl, sda) begin
      if (scl === 1'b1 && scl_p === 1'b1 && sda_p === 1'b1 && sda === 1'b0) begin
         {active, first} = 2'h3;
         {rd_mode, go_rd, quiet} = 3'h0;
         bitc = 4'h0;
      end else if (scl === 1'b1 && scl_p === 1'b1 && sda_p === 1'b0 && sda === 1'b1) begin
         active = 1'b0;
         pull_low = 1'b0;
      end else if (active && scl_p === 1'b0 && scl === 1'b1) begin
         // Rising clock: take address bits, or the master's ack after a data byte
         if (!rd_mode && bitc < 4'h8) sr = {sr[6:0], sda};
         if (rd_mode && bitc == 4'h8) quiet = sda;
         bitc = (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
      end else if (active && scl_p === 1'b1 && scl === 1'b0) begin
         // Falling clock: data may only change while the clock is low
         pull_low = 1'b0;
         if (bitc == 4'h0 && go_rd) begin
            rd_mode = 1'b1;
            go_rd = 1'b0;
         end
         if (bitc == 4'h8 && !rd_mode) begin
            if (first) begin
               ok = sr[7:1] == sel_pkg::DEV_WR_ADDR[7:1] && !refuse;
               go_rd = ok && sr[0];
               first = 1'b0;
            end else
               ptr = sr[3:0];
            pull_low = ok;
         end else if (rd_mode && !quiet && bitc < 4'h8) begin
            if (bitc == 4'h0) begin
               cur = image[ptr];
               ptr = ptr + 4'h1;
               n_sent = n_sent + 8'h01;
            end
            pull_low = !cur[7];
            cur = {cur[6:0], 1'b0};
         end
      end
      scl_p = scl;
      sda_p = sda;
   end

endmodule : sel_eeprom_model

/* File: sel_loader.sv */
// Serial EEPROM configuration loader: reads bytes 00..0E after reset and
// drives the loaded configuration; retries target accesses while loading.
// Assumes a two-wire memory at the usual address with external pull-ups.
//
// How it works
// R1: Load starts by itself after power-up reset.
// R2: Memory is reached only over two wires.
// R3: Target accesses get retry while loading.
// R4: Unique id from bytes 07-0E, low first.
// R5: Byte 00 gives latency and grant nibbles.
// R6: Vendor id from bytes 01 and 02.
// R7: Subsystem id from bytes 03 and 04.
// R8: Byte 05 bits 7,2,1,6 to link controls.
// R9: Addressed sequential read of bytes 00-0E.
//
// Local design decisions: the APB register port and the register addresses.
module sel_loader #(
   parameter int QTR_CYC = sel_pkg::SCL_QTR_CYC
) (
   // Clock and reset
   input  wire logic              MCLK,
   input  wire logic              RSTN,
   // APB slave
   input  wire logic [11:0]       PADDR,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [31:0]       PWDATA,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // Target access gate
   input  wire logic              TGT_REQ,
   output logic                   TGT_RETRY,
   output logic                   TGT_GRANT,
   // Two-wire memory pins
   output sel_pkg::sel_pin_t      SCL,
   output sel_pkg::sel_pin_t      SDA,
   input  wire logic              SDA_I,
   // Loaded configuration
   output sel_pkg::sel_cfg_t      CFG,
   output logic                   LOAD_BUSY
);
   typedef enum logic [8:0] {
      S_ST1 = 9'h001,
      S_DW  = 9'h002,
      S_AD  = 9'h004,
      S_ST2 = 9'h008,
      S_DR  = 9'h010,
      S_RD  = 9'h020,
      S_SP  = 9'h040,
      S_OK  = 9'h080,
      S_ERR = 9'h100
   } sel_state_t;

   sel_state_t        st_q, st_d;
   logic              pend_q, err_q, err_d;
   logic [3:0]        idx_q, idx_d;
   logic [7:0]        rom_q [sel_pkg::ROM_BYTES];
   sel_pkg::sel_cfg_t cfg_q;
   logic [31:0]       prdata_q;
   logic              eng_busy, eng_done, eng_nack, scl_rel, sda_rel;
   logic [7:0]        eng_rdata;
   sel_pkg::sel_cmd_t eng_cmd;
   logic [7:0]        eng_wdata;
   sel_pkg::sel_cfg_t cfg_img;

   // Command for each sequencing state
   wire busy     = (st_q != S_OK) && (st_q != S_ERR);
   wire eng_go   = busy && !pend_q; // [R1]
   wire last_rd  = (idx_q == sel_pkg::LAST_IDX);
   assign eng_cmd   = (st_q == S_ST1 || st_q == S_ST2) ? sel_pkg::CMD_START :
                      (st_q == S_SP) ? sel_pkg::CMD_STOP :
                      (st_q == S_RD) ? sel_pkg::CMD_READ : sel_pkg::CMD_WRITE;
   assign eng_wdata = (st_q == S_DW) ? sel_pkg::DEV_WR_ADDR :
                      (st_q == S_DR) ? sel_pkg::DEV_RD_ADDR : sel_pkg::FIRST_BYTE; // [R9]

   // APB decode; software reload is only taken once a load has ended
   wire apb_setup = PSEL && !PENABLE;
   wire apb_wr    = PSEL && PENABLE && PWRITE;
   wire hit       = (PADDR == sel_pkg::STATUS_OFS) || (PADDR == sel_pkg::CTRL_OFS) ||
                    (PADDR == sel_pkg::UIDH_OFS) || (PADDR == sel_pkg::UIDL_OFS) ||
                    (PADDR == sel_pkg::IDS_OFS) || (PADDR == sel_pkg::MISC_OFS);
   wire reload    = apb_wr && (PADDR == sel_pkg::CTRL_OFS) && PWDATA[sel_pkg::CTRL_RELOAD] && !busy;

   // Bus engine, all memory traffic goes through these two lines
   sel_bus_eng #(.QTR_CYC(QTR_CYC)) u_eng ( // [R2]
      .clk      (MCLK),
      .rst_n    (RSTN),
      .go       (eng_go),
      .cmd      (eng_cmd),
      .wdata    (eng_wdata),
      .send_ack (!last_rd),
      .busy     (eng_busy),
      .done     (eng_done),
      .rdata    (eng_rdata),
      .nack     (eng_nack),
      .scl_rel  (scl_rel),
      .sda_rel  (sda_rel),
      .sda_in   (SDA_I)
   );

   // Next state; a missing acknowledge ends the frame with a stop
   always_comb begin
      st_d  = st_q;
      err_d = err_q;
      idx_d = idx_q;
      unique case (st_q)
         S_ST1: if (eng_done) st_d = S_DW;
         S_DW: if (eng_done) begin
            st_d  = eng_nack ? S_SP : S_AD;
            err_d = eng_nack;
         end
         S_AD: if (eng_done) begin
            st_d  = eng_nack ? S_SP : S_ST2;
            err_d = eng_nack;
         end
         S_ST2: if (eng_done) st_d = S_DR;
         S_DR: if (eng_done) begin
            st_d  = eng_nack ? S_SP : S_RD; // [R9]
            err_d = eng_nack;
         end
         S_RD: if (eng_done) begin
            st_d  = last_rd ? S_SP : S_RD; // [R9]
            idx_d = last_rd ? idx_q : idx_q + 4'h1;
         end
         S_SP: if (eng_done) st_d = err_q ? S_ERR : S_OK;
         S_OK, S_ERR: if (reload) begin
            st_d  = S_ST1;
            err_d = 1'b0;
            idx_d = 4'h0;
         end
      endcase
   end

   // Sequencer; reset lands straight in the first start
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q   <= S_ST1; // [R1]
         pend_q <= 1'b0;
         err_q  <= 1'b0;
         idx_q  <= 4'h0;
      end else begin
         st_q   <= st_d;
         err_q  <= err_d;
         idx_q  <= idx_d;
         pend_q <= eng_done ? 1'b0 : (pend_q || eng_go);
      end
   end

   // Received image
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < sel_pkg::ROM_BYTES; i++)
            rom_q[i] <= 8'h00;
      end else if (st_q == S_RD && eng_done) begin
         rom_q[idx_q] <= eng_rdata; // [R9]
      end
   end

   // Assemble targets from the image
   assign cfg_img.unique_id_upper_word = {rom_q[sel_pkg::UIDH_IDX+3], rom_q[sel_pkg::UIDH_IDX+2],
                                          rom_q[sel_pkg::UIDH_IDX+1], rom_q[sel_pkg::UIDH_IDX]}; // [R4]
   assign cfg_img.unique_id_lower_word = {rom_q[sel_pkg::UIDL_IDX+3], rom_q[sel_pkg::UIDL_IDX+2],
                                          rom_q[sel_pkg::UIDL_IDX+1], rom_q[sel_pkg::UIDL_IDX]}; // [R4]
   assign cfg_img.max_latency  = rom_q[sel_pkg::LATGNT_IDX][7:4]; // [R5]
   assign cfg_img.min_grant    = rom_q[sel_pkg::LATGNT_IDX][3:0]; // [R5]
   assign cfg_img.vendor_id    = {rom_q[sel_pkg::VEN_HI_IDX], rom_q[sel_pkg::VEN_LO_IDX]}; // [R6]
   assign cfg_img.subsystem_id = {rom_q[sel_pkg::SUB_HI_IDX], rom_q[sel_pkg::SUB_LO_IDX]}; // [R7]
   assign cfg_img.enab_unfair            = rom_q[sel_pkg::LINK_IDX][sel_pkg::UNFAIR_BIT]; // [R8]
   assign cfg_img.enab_insert_idle       = rom_q[sel_pkg::LINK_IDX][sel_pkg::IDLE_BIT];   // [R8]
   assign cfg_img.enab_accel             = rom_q[sel_pkg::LINK_IDX][sel_pkg::ACCEL_BIT];  // [R8]
   assign cfg_img.phy_programming_enable = rom_q[sel_pkg::LINK_IDX][sel_pkg::PHYPRG_BIT]; // [R8]

   // Commit only a complete load, so a broken memory never leaves half values
   wire commit = (st_q == S_SP) && eng_done && !err_q;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN)
         cfg_q <= '0;
      else if (commit)
         cfg_q <= cfg_img;
   end

   // Read data captured in the setup phase
   wire [31:0] rd_mux =
      (PADDR == sel_pkg::STATUS_OFS) ? {29'h0, st_q == S_ERR, st_q == S_OK, busy} :
      (PADDR == sel_pkg::UIDH_OFS)   ? cfg_q.unique_id_upper_word :
      (PADDR == sel_pkg::UIDL_OFS)   ? cfg_q.unique_id_lower_word :
      (PADDR == sel_pkg::IDS_OFS)    ? {cfg_q.subsystem_id, cfg_q.vendor_id} :
      (PADDR == sel_pkg::MISC_OFS)   ? {16'h0, cfg_q.max_latency, cfg_q.min_grant,
                                        cfg_q.enab_unfair, cfg_q.phy_programming_enable, 3'h0,
                                        cfg_q.enab_insert_idle, cfg_q.enab_accel, 1'b0} :
      32'h0000_0000;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN)
         prdata_q <= 32'h0000_0000;
      else if (apb_setup)
         prdata_q <= rd_mux;
   end

   // Outputs; open-drain enables are high while pulling low
   assign PRDATA    = prdata_q;
   assign PREADY    = 1'b1;
   assign PSLVERR   = PSEL && PENABLE && !hit;
   assign TGT_RETRY = TGT_REQ && busy;  // [R3]
   assign TGT_GRANT = TGT_REQ && !busy; // [R3]
   assign SCL       = '{o: 1'b0, oe: !scl_rel};
   assign SDA       = '{o: 1'b0, oe: !sda_rel};
   assign CFG       = cfg_q;
   assign LOAD_BUSY = busy;

   // Checks
   start_kick_a: assert property (@(posedge MCLK) disable iff (!RSTN) // [R1]
      (st_q == S_ST1 && !pend_q) |=> eng_busy)
      else $error("load did not start");
   retry_gate_a: assert property (@(posedge MCLK) disable iff (!RSTN) // [R3]
      (TGT_REQ && eng_busy) |-> (TGT_RETRY && !TGT_GRANT))
      else $error("target access completed during load");
   uid_order_a: assert property (@(posedge MCLK) disable iff (!RSTN) // [R4]
      commit |=> (CFG.unique_id_upper_word[7:0] == $past(rom_q[7]) &&
                  CFG.unique_id_lower_word[31:24] == $past(rom_q[14])))
      else $error("unique id byte order wrong");
   lat_gnt_a: assert property (@(posedge MCLK) disable iff (!RSTN) // [R5]
      commit |=> ({CFG.max_latency, CFG.min_grant} == $past(rom_q[0])))
      else $error("latency or grant wrong");
   vendor_id_a: assert property (@(posedge MCLK) disable iff (!RSTN) // [R6]
      commit |=> (CFG.vendor_id == {$past(rom_q[2]), $past(rom_q[1])}))
      else $error("vendor id wrong");
   subsys_id_a: assert property (@(posedge MCLK) disable iff (!RSTN) // [R7]
      commit |=> (CFG.subsystem_id == {$past(rom_q[4]), $past(rom_q[3])}))
      else $error("subsystem id wrong");
   link_bits_a: assert property (@(posedge MCLK) disable iff (!RSTN) // [R8]
      commit |=> ({CFG.enab_unfair, CFG.phy_programming_enable, CFG.enab_insert_idle,
                   CFG.enab_accel} == {$past(rom_q[5][7]), $past(rom_q[5][6]),
                                       $past(rom_q[5][2]), $past(rom_q[5][1])}))
      else $error("link control bits wrong");
   read_end_a: assert property (@(posedge MCLK) disable iff (!RSTN) // [R9]
      (st_q == S_RD && eng_done && idx_q == 4'he) |=> (st_q == S_SP && rom_q[14] == $past(eng_rdata)))
      else $error("read did not end after byte 0e");

endmodule : sel_loader

/* File: sel_loader_tb.sv */
// Self-checking bench of the configuration loader: power-up load, reloads, refused address.
// Assumes the memory model beside it and pull-ups on both wires.
module sel_loader_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int QTR = 2;
   localparam logic [14:0][7:0] IMG_A = {8'h88, 8'h77, 8'h66, 8'h55, 8'h44, 8'h33, 8'h22,
      8'h11, 8'hff, 8'hc6, 8'h56, 8'h78, 8'h12, 8'h34, 8'h5a};
   localparam logic [14:0][7:0] IMG_B = {8'h0f, 8'h1e, 8'h2d, 8'h3c, 8'h4b, 8'h5a, 8'h69,
      8'h78, 8'h00, 8'h39, 8'hef, 8'h01, 8'hab, 8'hcd, 8'ha5};

   logic              mclk, rstn, psel, penable, pwrite, tgt_req, refuse, mem_low;
   logic              pready, pslverr, tgt_retry, tgt_grant, load_busy, sda_i, scl_w;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, d;
   logic              er;
   logic [14:0][7:0]  img;
   logic [7:0]        n_sent;
   sel_pkg::sel_pin_t scl, sda;
   sel_pkg::sel_cfg_t cfg;
   int                errors, n_compared;

   // Wired-AND of both wires with pull-ups
   assign scl_w = !(scl.oe === 1'b1);
   assign sda_i = !(sda.oe === 1'b1 || mem_low);

   sel_loader #(.QTR_CYC(QTR)) sel_loader_i (.MCLK(mclk), .RSTN(rstn), .PADDR(paddr),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TGT_REQ(tgt_req), .TGT_RETRY(tgt_retry),
      .TGT_GRANT(tgt_grant), .SCL(scl), .SDA(sda), .SDA_I(sda_i), .CFG(cfg),
      .LOAD_BUSY(load_busy));

   sel_eeprom_model sel_eeprom_model_i (.scl(scl_w), .sda(sda_i), .image(img),
      .refuse(refuse), .pull_low(mem_low), .n_sent(n_sent));

   // 25 MHz core clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up

   // One APB transfer; held until pready is seen high at a rising edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd, output logic e);
      @(posedge mclk);
      {psel, penable, pwrite} <= {1'b1, 1'b0, w};
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
   endtask : apb

   // Expected outputs worked out from a memory image
   function automatic sel_pkg::sel_cfg_t exp_cfg(input logic [14:0][7:0] m);
      sel_pkg::sel_cfg_t c;
      c = '0;
      c.unique_id_upper_word = {m[10], m[9], m[8], m[7]};
      c.unique_id_lower_word = {m[14], m[13], m[12], m[11]};
      c.vendor_id = {m[2], m[1]};
      c.subsystem_id = {m[4], m[3]};
      {c.max_latency, c.min_grant} = m[0];
      {c.enab_unfair, c.phy_programming_enable} = m[5][7:6];
      {c.enab_insert_idle, c.enab_accel} = m[5][2:1];
      return c;
   endfunction : exp_cfg

   // Waits out a load, then checks outputs and registers; st is the expected busy, done and error bits
   task automatic expect_cfg(input sel_pkg::sel_cfg_t e, input logic [31:0] st);
      for (int k = 0; k < 20000 && load_busy !== 1'b0; k++) @(negedge mclk);
      check(32'(load_busy), 32'h0);
      check(32'({tgt_retry, tgt_grant}), 32'h1);
      check(cfg.unique_id_upper_word, e.unique_id_upper_word);
      check(cfg.unique_id_lower_word, e.unique_id_lower_word);
      check(32'({cfg.max_latency, cfg.min_grant}), 32'({e.max_latency, e.min_grant}));
      check(32'(cfg.vendor_id), 32'(e.vendor_id));
      check(32'(cfg.subsystem_id), 32'(e.subsystem_id));
      check(32'({cfg.enab_unfair, cfg.phy_programming_enable, cfg.enab_insert_idle,
         cfg.enab_accel}), 32'({e.enab_unfair, e.phy_programming_enable,
         e.enab_insert_idle, e.enab_accel}));
      apb(sel_pkg::STATUS_OFS, 1'b0, 32'h0, d, er);
      check(d & 32'h0000_0007, st);
      apb(sel_pkg::UIDH_OFS, 1'b0, 32'h0, d, er);
      check(d, e.unique_id_upper_word);
      apb(sel_pkg::UIDL_OFS, 1'b0, 32'h0, d, er);
      check(d, e.unique_id_lower_word);
      apb(sel_pkg::IDS_OFS, 1'b0, 32'h0, d, er);
      check(d, {e.subsystem_id, e.vendor_id});
      apb(sel_pkg::MISC_OFS, 1'b0, 32'h0, d, er);
      check(d, {16'h0, e.max_latency, e.min_grant, e.enab_unfair, e.phy_programming_enable,
         3'h0, e.enab_insert_idle, e.enab_accel, 1'h0});
   endtask : expect_cfg

   // Starts a reload and checks that target accesses are retried meanwhile
   task automatic reload();
      apb(sel_pkg::CTRL_OFS, 1'b1, 32'h1, d, er);
      repeat (3) @(negedge mclk);
      check(32'({load_busy, tgt_retry, tgt_grant}), 32'h6);
      // No request presented: neither retry nor grant, even mid-load
      @(posedge mclk) tgt_req <= 1'b0;
      @(negedge mclk) check(32'({load_busy, tgt_retry, tgt_grant}), 32'h4);
      @(posedge mclk) tgt_req <= 1'b1;
   endtask : reload

   // Main sequence
   initial begin
      {rstn, psel, penable, pwrite, refuse} = 5'h0;
      tgt_req = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      img = IMG_A;
      errors = 0;
      n_compared = 0;
      repeat (12) @(posedge mclk);
      check(32'({load_busy, |cfg, scl.oe, sda.oe}), 32'h8);
      rstn <= 1'b1;
      repeat (3) @(negedge mclk);
      check(32'({load_busy, tgt_retry, tgt_grant}), 32'h6);
      expect_cfg(exp_cfg(IMG_A), 32'h2);
      check(32'(n_sent), 32'd15);
      apb(12'h020, 1'b0, 32'h0, d, er);
      check({d[30:0], er}, 32'h1);
      // Second reload request during a load must not add a third pass
      img <= IMG_B;
      reload();
      apb(sel_pkg::CTRL_OFS, 1'b1, 32'h1, d, er);
      expect_cfg(exp_cfg(IMG_B), 32'h2);
      check(32'(n_sent), 32'd30);
      // Refused address: error flagged, previous values kept
      refuse <= 1'b1;
      reload();
      expect_cfg(exp_cfg(IMG_B), 32'h4);
      check(32'(n_sent), 32'd30);
      check(32'({scl.o, sda.o, scl.oe, sda.oe}), 32'h0);
      wrap_up();
   end

   // Hang guard, well past two full loads of about 1360 cycles each and one refused load
   initial begin
      repeat (30000) @(posedge mclk);
      errors++;
      $display("MISMATCH at %0t: timeout", $time);
      wrap_up();
   end

endmodule : sel_loader_tb

/* File: sel_pkg.sv */
// Shared constants and types of the serial EEPROM configuration loader.
// Assumes a 25 MHz core clock and a standard-mode two-wire memory.
package sel_pkg;

   // Clock and serial bit timing, quarter of a 100 kHz bit period
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCL_QTR_NS    = 2500;
   localparam int SCL_QTR_CYC   = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Memory addressing on the two-wire bus
   localparam logic [7:0] DEV_WR_ADDR = 8'ha0;
   localparam logic [7:0] DEV_RD_ADDR = 8'ha1;
   localparam logic [7:0] FIRST_BYTE  = 8'h00;
   localparam int         ROM_BYTES   = 15;
   localparam logic [3:0] LAST_IDX    = 4'he;

   // Byte map of the memory image
   localparam int LATGNT_IDX = 0;
   localparam int VEN_LO_IDX = 1;
   localparam int VEN_HI_IDX = 2;
   localparam int SUB_LO_IDX = 3;
   localparam int SUB_HI_IDX = 4;
   localparam int LINK_IDX   = 5;
   localparam int UIDH_IDX   = 7;
   localparam int UIDL_IDX   = 11;
   localparam int UNFAIR_BIT = 7;
   localparam int PHYPRG_BIT = 6;
   localparam int IDLE_BIT   = 2;
   localparam int ACCEL_BIT  = 1;

   // Register offsets and field positions on APB
   localparam logic [11:0] STATUS_OFS = 12'h000;
   localparam logic [11:0] CTRL_OFS   = 12'h004;
   localparam logic [11:0] UIDH_OFS   = 12'h008;
   localparam logic [11:0] UIDL_OFS   = 12'h00c;
   localparam logic [11:0] IDS_OFS    = 12'h010;
   localparam logic [11:0] MISC_OFS   = 12'h014;
   localparam int          ST_BUSY    = 0;
   localparam int          ST_DONE    = 1;
   localparam int          ST_ERR     = 2;
   localparam int          CTRL_RELOAD = 0;

   // Byte-level commands of the bus engine
   typedef enum logic [1:0] {
      CMD_START = 2'h0,
      CMD_STOP  = 2'h1,
      CMD_WRITE = 2'h2,
      CMD_READ  = 2'h3
   } sel_cmd_t;

   // Open-drain pin drive
   typedef struct packed {
      logic o;
      logic oe;
   } sel_pin_t;

   // Loaded configuration values
   typedef struct packed {
      logic [31:0] unique_id_upper_word;
      logic [31:0] unique_id_lower_word;
      logic [15:0] vendor_id;
      logic [15:0] subsystem_id;
      logic [3:0]  max_latency;
      logic [3:0]  min_grant;
      logic        enab_unfair;
      logic        enab_insert_idle;
      logic        enab_accel;
      logic        phy_programming_enable;
   } sel_cfg_t;

endpackage : sel_pkg
